// file: verilog/rtcev_top.v
// Event output enables, interrupt enables and read synchronisation of the real-time counter
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rtcev_map.vh"

module rtcev_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ovf_tgl,
    input  wire        compare0_irq_enable_tgl,
    input  wire        cmp1_tgl,
    input  wire [7:0]  per_tgl,
    input  wire        sync_ack_tgl,
    input  wire [31:0] count_value,
    output reg         sync_req_tgl,
    output reg         ev_ovf,
    output reg         ev_compare0_irq_enable,
    output reg         ev_cmp1,
    output reg         ev_alarm0,
    output reg  [7:0]  ev_per,
    output reg         irq
);

    // Register storage
    reg  [15:0] ctrl_r;
    reg  [15:0] event_output_control_r;
    reg         wprot_r;
    reg         busy_r;
    reg  [31:0] count_q_r;

    // Bus decode
    wire        acc_phase;
    wire        wr_take;
    wire [5:0]  idx;
    wire        addr_ok;
    wire        idx_mapped;
    reg         idx_mapped_c;
    reg  [31:0] rd_nxt;

    // Synchronised pulses from the counter domain
    wire        ovf_p;
    wire        compare0_irq_enable_p;
    wire        cmp1_p;
    wire [7:0]  per_p;
    wire        ack_p;

    // Interrupt sources
    wire        flag_ovf;
    wire        flag_sync;
    wire        flag_compare0_irq_enable;
    wire        flag_cmp1;
    wire        en_ovf;
    wire        en_sync;
    wire        en_compare0_irq_enable;
    wire        en_cmp1;
    wire        req_ovf;
    wire        req_sync;
    wire        req_compare0_irq_enable;
    wire        req_cmp1;

    // Mode and protection
    wire [1:0]  mode;
    wire        mode_wide;
    wire        mode_half;
    wire        mode_cal;
    wire        periph_on;
    reg  [15:0] evmask;

    // Write strobes per register
    wire        wr_ctrl;
    wire        wr_readreq;
    wire        wr_event_output_control;
    wire        wr_enclr;
    wire        wr_enset;
    wire        wr_flagclr;
    wire        wr_wprot;
    wire [7:0]  wbyte;

    assign mode      = ctrl_r[`RTCEV_CTRL_MODE_HI:`RTCEV_CTRL_MODE_LO];
    assign mode_wide = (mode == `RTCEV_MODE_WIDE);
    assign mode_half = (mode == `RTCEV_MODE_HALF);
    assign mode_cal  = (mode == `RTCEV_MODE_CAL);
    assign periph_on = ctrl_r[`RTCEV_CTRL_ENABLE];

    // Writable event control bits follow the mode layout
    always @* begin
        case (mode)
            `RTCEV_MODE_WIDE: evmask = `RTCEV_EVMASK_WIDE;
            `RTCEV_MODE_HALF: evmask = `RTCEV_EVMASK_HALF;
            `RTCEV_MODE_CAL:  evmask = `RTCEV_EVMASK_CAL;
            default:          evmask = 16'h0000;
        endcase
    end

    // APB decode: word aligned, index in address bits 7 to 2, bits 11 to 8 zero
    assign acc_phase  = psel & penable;
    assign wr_take    = acc_phase & pready & pwrite & ~pslverr;
    assign idx        = paddr[7:2];
    assign addr_ok    = (paddr[1:0] == 2'b00) && (paddr[11:8] == 4'h0);
    assign idx_mapped = addr_ok & idx_mapped_c;
    assign wbyte      = pwdata[7:0];

    // Index table of mapped registers
    always @* begin
        case (idx)
            `RTCEV_IDX_CTRL:       idx_mapped_c = 1'b1;
            `RTCEV_IDX_READREQ:    idx_mapped_c = 1'b1;
            `RTCEV_IDX_EVENT_OUTPUT_CONTROL:     idx_mapped_c = 1'b1;
            `RTCEV_IDX_INTERRUPT_ENABLE_CLEAR:   idx_mapped_c = 1'b1;
            `RTCEV_IDX_INTERRUPT_ENABLE_SET:   idx_mapped_c = 1'b1;
            `RTCEV_IDX_INTFLAG:    idx_mapped_c = 1'b1;
            `RTCEV_IDX_INTFLAGCLR: idx_mapped_c = 1'b1;
            `RTCEV_IDX_STATUS:     idx_mapped_c = 1'b1;
            `RTCEV_IDX_COUNT:      idx_mapped_c = 1'b1;
            `RTCEV_IDX_WPROT:      idx_mapped_c = 1'b1;
            default:               idx_mapped_c = 1'b0;
        endcase
    end

    // Write strobes; protected registers ignore writes while locked
    assign wr_ctrl    = wr_take & (idx == `RTCEV_IDX_CTRL) & ~wprot_r;
    assign wr_readreq = wr_take & (idx == `RTCEV_IDX_READREQ);
    assign wr_event_output_control  = wr_take & (idx == `RTCEV_IDX_EVENT_OUTPUT_CONTROL) & ~wprot_r & ~periph_on;
    assign wr_enclr   = wr_take & (idx == `RTCEV_IDX_INTERRUPT_ENABLE_CLEAR) & ~wprot_r;
    assign wr_enset   = wr_take & (idx == `RTCEV_IDX_INTERRUPT_ENABLE_SET) & ~wprot_r;
    assign wr_flagclr = wr_take & (idx == `RTCEV_IDX_INTFLAGCLR);
    assign wr_wprot   = wr_take & (idx == `RTCEV_IDX_WPROT);

    // Read mux
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (idx)
            `RTCEV_IDX_CTRL:     rd_nxt = {16'h0000, ctrl_r};
            `RTCEV_IDX_READREQ:  rd_nxt = {26'h0000000, `RTCEV_SYNC_TARGET};
            `RTCEV_IDX_EVENT_OUTPUT_CONTROL:   rd_nxt = {16'h0000, event_output_control_r};
            `RTCEV_IDX_INTERRUPT_ENABLE_CLEAR: rd_nxt = {24'h000000, en_ovf, en_sync, 4'h0, en_cmp1, en_compare0_irq_enable};
            `RTCEV_IDX_INTERRUPT_ENABLE_SET: rd_nxt = {24'h000000, en_ovf, en_sync, 4'h0, en_cmp1, en_compare0_irq_enable};
            `RTCEV_IDX_INTFLAG:  rd_nxt = {24'h000000, flag_ovf, flag_sync, 4'h0, flag_cmp1, flag_compare0_irq_enable};
            `RTCEV_IDX_STATUS:   rd_nxt = {24'h000000, busy_r, 7'h00};
            `RTCEV_IDX_COUNT:    rd_nxt = count_q_r;
            `RTCEV_IDX_WPROT:    rd_nxt = {31'h00000000, wprot_r};
            default:             rd_nxt = 32'h0000_0000;
        endcase
    end

    // APB slave: one wait state, then ready with data or error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            if (acc_phase && !pready) begin
                pready  <= 1'b1;
                pslverr <= ~idx_mapped;
                prdata  <= (idx_mapped && !pwrite) ? rd_nxt : 32'h0000_0000;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
        end
    end

    // Control, event control and protection registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= `RTCEV_RST_CTRL;
            event_output_control_r <= `RTCEV_RST_EVENT_OUTPUT_CONTROL;
            wprot_r  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {12'h000, pwdata[3:1], 1'b0};
            end
            if (wr_event_output_control) begin
                event_output_control_r <= pwdata[15:0] & evmask;
            end
            if (wr_wprot) begin
                wprot_r <= pwdata[0];
            end
        end
    end

    // Read synchronisation: toggle out, wait for acknowledge, capture value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r       <= 1'b0;
            sync_req_tgl <= 1'b0;
            count_q_r    <= 32'h0000_0000;
        end else begin
            if (ack_p && busy_r) begin
                busy_r    <= 1'b0;
                count_q_r <= count_value;
            end else if (wr_readreq && pwdata[`RTCEV_READ_SYNC_REQUEST_BIT] && !busy_r) begin
                busy_r       <= 1'b1;
                sync_req_tgl <= ~sync_req_tgl;
            end
        end
    end

    // Counter-domain events through three-flop synchronisers
    rtcev_evsync u_sync_ovf (
        .pclk    (pclk),
        .presetn (presetn),
        .tgl_in  (ovf_tgl),
        .pulse   (ovf_p)
    );

    rtcev_evsync u_sync_compare0_irq_enable (
        .pclk    (pclk),
        .presetn (presetn),
        .tgl_in  (compare0_irq_enable_tgl),
        .pulse   (compare0_irq_enable_p)
    );

    rtcev_evsync u_sync_cmp1 (
        .pclk    (pclk),
        .presetn (presetn),
        .tgl_in  (cmp1_tgl),
        .pulse   (cmp1_p)
    );

    rtcev_evsync u_sync_ack (
        .pclk    (pclk),
        .presetn (presetn),
        .tgl_in  (sync_ack_tgl),
        .pulse   (ack_p)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_per
            rtcev_evsync u_sync_per (
                .pclk    (pclk),
                .presetn (presetn),
                .tgl_in  (per_tgl[gi]),
                .pulse   (per_p[gi])
            );
        end
    endgenerate

    // Gated event outputs, one cycle each
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_ovf    <= 1'b0;
            ev_compare0_irq_enable   <= 1'b0;
            ev_cmp1   <= 1'b0;
            ev_alarm0 <= 1'b0;
            ev_per    <= 8'h00;
        end else begin
            ev_ovf    <= ovf_p & event_output_control_r[`RTCEV_EV_OVF];
            ev_compare0_irq_enable   <= compare0_irq_enable_p & event_output_control_r[`RTCEV_EV_COMPARE0_IRQ_ENABLE] & (mode_wide | mode_half);
            ev_cmp1   <= cmp1_p & event_output_control_r[`RTCEV_EV_CMP1] & mode_half;
            ev_alarm0 <= compare0_irq_enable_p & event_output_control_r[`RTCEV_EV_COMPARE0_IRQ_ENABLE] & mode_cal;
            ev_per    <= per_p & event_output_control_r[`RTCEV_EV_PER_HI:`RTCEV_EV_PER_LO];
        end
    end

    // Interrupt sources; clear bits only act on ones
    rtcev_irqbit u_irq_ovf (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_ev   (ovf_p),
        .flag_clr (wr_flagclr & wbyte[`RTCEV_INT_OVF]),
        .en_set   (wr_enset & wbyte[`RTCEV_INT_OVF]),
        .en_clr   (wr_enclr & wbyte[`RTCEV_INT_OVF]),
        .flag     (flag_ovf),
        .en       (en_ovf),
        .req      (req_ovf)
    );

    rtcev_irqbit u_irq_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_ev   (ack_p & busy_r),
        .flag_clr (wr_flagclr & wbyte[`RTCEV_INT_SYNC_READY_IRQ_ENABLE]),
        .en_set   (wr_enset & wbyte[`RTCEV_INT_SYNC_READY_IRQ_ENABLE]),
        .en_clr   (wr_enclr & wbyte[`RTCEV_INT_SYNC_READY_IRQ_ENABLE]),
        .flag     (flag_sync),
        .en       (en_sync),
        .req      (req_sync)
    );

    rtcev_irqbit u_irq_compare0_irq_enable (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_ev   (compare0_irq_enable_p),
        .flag_clr (wr_flagclr & wbyte[`RTCEV_INT_COMPARE0_IRQ_ENABLE]),
        .en_set   (wr_enset & wbyte[`RTCEV_INT_COMPARE0_IRQ_ENABLE]),
        .en_clr   (wr_enclr & wbyte[`RTCEV_INT_COMPARE0_IRQ_ENABLE]),
        .flag     (flag_compare0_irq_enable),
        .en       (en_compare0_irq_enable),
        .req      (req_compare0_irq_enable)
    );

    rtcev_irqbit u_irq_cmp1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_ev   (cmp1_p & mode_half),
        .flag_clr (wr_flagclr & wbyte[`RTCEV_INT_CMP1]),
        .en_set   (wr_enset & wbyte[`RTCEV_INT_CMP1] & mode_half),
        .en_clr   (wr_enclr & wbyte[`RTCEV_INT_CMP1]),
        .flag     (flag_cmp1),
        .en       (en_cmp1),
        .req      (req_cmp1)
    );

    // Level interrupt output from any enabled flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= req_ovf | req_sync | req_compare0_irq_enable | req_cmp1;
        end
    end

endmodule // rtcev_top

`default_nettype wire

// file: verilog/rtcev_map.vh
// Register indices, field positions, reset values and mode codes of the event and interrupt block
`ifndef RTCEV_MAP_VH
`define RTCEV_MAP_VH

// Register indices; the byte address is four times the index
`define RTCEV_IDX_CTRL       6'h00
`define RTCEV_IDX_READREQ    6'h02
`define RTCEV_IDX_EVENT_OUTPUT_CONTROL     6'h04
`define RTCEV_IDX_INTERRUPT_ENABLE_CLEAR   6'h06
`define RTCEV_IDX_INTERRUPT_ENABLE_SET   6'h07
`define RTCEV_IDX_INTFLAG    6'h08
`define RTCEV_IDX_INTFLAGCLR 6'h09
`define RTCEV_IDX_STATUS     6'h0a
`define RTCEV_IDX_COUNT      6'h10
`define RTCEV_IDX_WPROT      6'h20

// Fixed read synchronisation target
`define RTCEV_SYNC_TARGET    6'h10

// Control register fields
`define RTCEV_CTRL_ENABLE    1
`define RTCEV_CTRL_MODE_LO   2
`define RTCEV_CTRL_MODE_HI   3

// Read request fields
`define RTCEV_READ_SYNC_REQUEST_BIT       15

// Event control fields
`define RTCEV_EV_OVF         15
`define RTCEV_EV_CMP1        9
`define RTCEV_EV_COMPARE0_IRQ_ENABLE        8
`define RTCEV_EV_PER_HI      7
`define RTCEV_EV_PER_LO      0

// Writable masks of the event control register per mode
`define RTCEV_EVMASK_WIDE    16'h81ff
`define RTCEV_EVMASK_HALF    16'h83ff
`define RTCEV_EVMASK_CAL     16'h81ff

// Interrupt enable and flag fields
`define RTCEV_INT_OVF        7
`define RTCEV_INT_SYNC_READY_IRQ_ENABLE    6
`define RTCEV_INT_CMP1       1
`define RTCEV_INT_COMPARE0_IRQ_ENABLE       0

// Status fields
`define RTCEV_STAT_BUSY      7

// Operating modes
`define RTCEV_MODE_WIDE      2'h0
`define RTCEV_MODE_HALF      2'h1
`define RTCEV_MODE_CAL       2'h2

// Reset values
`define RTCEV_RST_CTRL       16'h0000
`define RTCEV_RST_EVENT_OUTPUT_CONTROL     16'h0000
`define RTCEV_RST_INTEN      8'h00

`endif

// file: verilog/rtcev_evsync.v
// Three-stage toggle synchroniser that turns a far-domain toggle into a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none

module rtcev_evsync (
    input  wire pclk,
    input  wire presetn,
    input  wire tgl_in,
    output reg  pulse
);

    reg stage1_r;
    reg stage2_r;
    reg stage3_r;
    reg accepted_r;

    // Three flops; a change counts once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r   <= 1'b0;
            stage2_r   <= 1'b0;
            stage3_r   <= 1'b0;
            accepted_r <= 1'b0;
            pulse      <= 1'b0;
        end else begin
            stage1_r <= tgl_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            pulse    <= 1'b0;
            if ((stage2_r == stage3_r) && (stage3_r != accepted_r)) begin
                accepted_r <= stage3_r;
                pulse      <= 1'b1;
            end
        end
    end

endmodule // rtcev_evsync

`default_nettype wire

// file: verilog/rtcev_irqbit.v
// One interrupt source: sticky flag, enable with set and clear, masked request
`timescale 1ns/10ps
`default_nettype none

module rtcev_irqbit (
    input  wire pclk,
    input  wire presetn,
    input  wire set_ev,
    input  wire flag_clr,
    input  wire en_set,
    input  wire en_clr,
    output reg  flag,
    output reg  en,
    output wire req
);

    // Flag set wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
            en   <= 1'b0;
        end else begin
            if (set_ev) begin
                flag <= 1'b1;
            end else if (flag_clr) begin
                flag <= 1'b0;
            end
            if (en_set) begin
                en <= 1'b1;
            end else if (en_clr) begin
                en <= 1'b0;
            end
        end
    end

    // Request only while flag and enable are both high
    assign req = flag & en;

endmodule // rtcev_irqbit

`default_nettype wire

// file: bench/rtcev_sva.sv
// Checker of bus timing, event pulses and interrupt release of the block
`timescale 1ns/10ps
`default_nettype none
`include "rtcev_map.vh"
module rtcev_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ovf_tgl,
    input wire logic        sync_req_tgl,
    input wire logic        ev_ovf,
    input wire logic [7:0]  ev_per,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed writes, and those that ask for a read sync
    wire logic wr_done = pready && pwrite;
    wire logic rr_wr   = wr_done && paddr[7:2] == `RTCEV_IDX_READREQ && pwdata[`RTCEV_READ_SYNC_REQUEST_BIT];
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_next: assert property (s_take |=> s_answer)
        else $error("access not answered in one cycle");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside answer");
    a_target_const: assert property (pready && !pslverr && !pwrite && paddr[7:2] == `RTCEV_IDX_READREQ |-> prdata[5:0] == 6'h10)
        else $error("sync target field not constant");
    a_ovf_pulse: assert property (ev_ovf |=> !ev_ovf)
        else $error("overflow event longer than one cycle");
    a_per_pulse: assert property (|ev_per |=> (ev_per & $past(ev_per)) == 8'h0)
        else $error("periodic event longer than one cycle");
    a_ovf_cause: assert property (ev_ovf |-> $past(ovf_tgl, 2) != $past(ovf_tgl, 8))
        else $error("overflow event without overflow");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("interrupt dropped without a write");
    a_sync_kick: assert property ($changed(sync_req_tgl) |-> $past(rr_wr, 1) || $past(rr_wr, 2))
        else $error("sync request without read request write");
endmodule // rtcev_sva

bind rtcev_top rtcev_sva rtcev_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovf_tgl(ovf_tgl), .sync_req_tgl(sync_req_tgl), .ev_ovf(ev_ovf), .ev_per(ev_per), .irq(irq));
`default_nettype wire

// file: bench/rtcev_far.sv
// Counter-domain model: event toggles on command and answers to read sync
`timescale 1ns/10ps
`default_nettype none
module rtcev_far (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [10:0] fire,
    input  wire logic [31:0] val,
    input  wire logic        sync_req_tgl,
    output var  logic        ovf_tgl,
    output var  logic        compare0_irq_enable_tgl,
    output var  logic        cmp1_tgl,
    output var  logic [7:0]  per_tgl,
    output var  logic        sync_ack_tgl,
    output var  logic [31:0] count_value
);
    logic       req_d;
    logic       slow_r;
    logic [3:0] wait_r;
    logic [3:0] hold_r;
    // Answers alternate prompt and slow; value only stable around the acknowledge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {per_tgl, cmp1_tgl, compare0_irq_enable_tgl, ovf_tgl} <= 11'h0;
            {req_d, slow_r, sync_ack_tgl} <= 3'h0;
            {wait_r, hold_r} <= 8'h0;
            count_value <= 32'h0;
        end else begin
            {per_tgl, cmp1_tgl, compare0_irq_enable_tgl, ovf_tgl} <= {per_tgl, cmp1_tgl, compare0_irq_enable_tgl, ovf_tgl} ^ fire;
            req_d <= sync_req_tgl;
            if (hold_r != 4'h0) begin
                hold_r <= hold_r - 4'h1;
            end
            if (sync_req_tgl != req_d) begin
                wait_r <= slow_r ? 4'h9 : 4'h2;
                slow_r <= ~slow_r;
            end else if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
                if (wait_r == 4'h1) begin
                    sync_ack_tgl <= ~sync_ack_tgl;
                    hold_r <= 4'h8;
                end
            end
            count_value <= (hold_r != 4'h0 || wait_r == 4'h1) ? val : ~count_value;
        end
    end
endmodule // rtcev_far
`default_nettype wire

// file: bench/tb_top.sv
// Testbench of the event and interrupt block with its counter-domain model
`timescale 1ns/10ps
`default_nettype none
`include "rtcev_map.vh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
    logic        ovf_t, compare0_irq_enable_t, cmp1_t, ack_t, req_t, ev_ovf, ev_compare0_irq_enable, ev_cmp1, ev_alarm0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, count_value, val, q;
    logic [7:0]  per_t, ev_per;
    logic [10:0] fire;
    integer      seed = 68;
    integer      error_cnt = 0;
    integer      checks = 0;
    int          cnt[12], base[12];
    wire  [11:0] evv = {ev_per, ev_alarm0, ev_cmp1, ev_compare0_irq_enable, ev_ovf};

    rtcev_top rtcev_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ovf_tgl(ovf_t),
        .compare0_irq_enable_tgl(compare0_irq_enable_t), .cmp1_tgl(cmp1_t), .per_tgl(per_t), .sync_ack_tgl(ack_t), .count_value(count_value),
        .sync_req_tgl(req_t), .ev_ovf(ev_ovf), .ev_compare0_irq_enable(ev_compare0_irq_enable), .ev_cmp1(ev_cmp1), .ev_alarm0(ev_alarm0),
        .ev_per(ev_per), .irq(irq));
    rtcev_far rtcev_far_i (.pclk(pclk), .presetn(presetn), .fire(fire), .val(val), .sync_req_tgl(req_t),
        .ovf_tgl(ovf_t), .compare0_irq_enable_tgl(compare0_irq_enable_t), .cmp1_tgl(cmp1_t), .per_tgl(per_t), .sync_ack_tgl(ack_t),
        .count_value(count_value));

    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #2000000;
        error_cnt++;
        wrap_up;
    end
    // Event pulse counters
    always @(posedge pclk) begin
        foreach (cnt[i]) cnt[i] <= cnt[i] + int'(evv[i]);
    end

    task automatic wrap_up;
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        apb(1'b1, {4'h0, i, 2'h0}, d);
    endtask
    task automatic rd(input logic [5:0] i, input logic [31:0] exp);
        apb(1'b0, {4'h0, i, 2'h0}, 32'h0);
        chk(q, exp);
    endtask
    task automatic kick(input logic [10:0] f);
        @(posedge pclk);
        fire <= f;
        @(posedge pclk);
        fire <= 11'h0;
        repeat (12) @(posedge pclk);
    endtask
    task automatic irq_is(input logic b);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, b});
    endtask
    function automatic logic [11:0] ev_exp(input logic [1:0] m, input logic [15:0] r);
        ev_exp = {r[7:0], r[8] && m == `RTCEV_MODE_CAL, r[9] && m == `RTCEV_MODE_HALF, r[8] && m != `RTCEV_MODE_CAL, r[15]};
    endfunction

    // Main sequence
    initial begin
        logic [15:0] r;
        logic [11:0] e;
        {presetn, psel, penable, pwrite, fire, paddr, pwdata, val} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, 32'h0);
        rd(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h0);
        wr(`RTCEV_IDX_READREQ, 32'h3f);
        rd(`RTCEV_IDX_READREQ, 32'h10);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, i ? 12'h012 : 12'h00c, 32'h0);
            chk({err, q[30:0]}, 32'h80000000);
        end
        // Every mode with all, none and random event enables
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 3; k++) begin
                r = k == 0 ? 16'hffff : k == 1 ? 16'h0 : 16'($random(seed));
                wr(`RTCEV_IDX_CTRL, 32'(m) << 2);
                wr(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, r});
                r = r & (m == 1 ? `RTCEV_EVMASK_HALF : `RTCEV_EVMASK_WIDE);
                rd(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, r});
                base = cnt;
                kick(11'h7ff);
                kick(11'h7ff);
                e = ev_exp(2'(m), r);
                for (int i = 0; i < 12; i++) begin
                    chk(cnt[i] - base[i], 2 * e[i]);
                end
            end
        end
        // Protected while enabled or locked
        wr(`RTCEV_IDX_CTRL, 32'h0a);
        wr(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, ~r});
        rd(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, r});
        wr(`RTCEV_IDX_CTRL, 32'h08);
        wr(`RTCEV_IDX_WPROT, 32'h1);
        wr(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, ~r});
        rd(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, {16'h0, r});
        wr(`RTCEV_IDX_WPROT, 32'h0);
        // Reserved mode leaves no event control bit writable
        wr(`RTCEV_IDX_CTRL, 32'h0c);
        wr(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, 32'hffff);
        rd(`RTCEV_IDX_EVENT_OUTPUT_CONTROL, 32'h0);
        wr(`RTCEV_IDX_CTRL, 32'h0);
        // Enables, masking and requests; flags left by the event runs go first
        wr(`RTCEV_IDX_INTFLAGCLR, 32'hff);
        wr(`RTCEV_IDX_INTERRUPT_ENABLE_SET, 32'hc1);
        rd(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'hc1);
        irq_is(1'b0);
        wr(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h0);
        rd(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'hc1);
        kick(11'h1);
        irq_is(1'b1);
        wr(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h80);
        rd(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h41);
        irq_is(1'b0);
        wr(`RTCEV_IDX_INTFLAGCLR, 32'h80);
        kick(11'h2);
        irq_is(1'b1);
        wr(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h01);
        rd(`RTCEV_IDX_INTERRUPT_ENABLE_CLEAR, 32'h40);
        irq_is(1'b0);
        wr(`RTCEV_IDX_INTFLAGCLR, 32'h01);
        // Read sync, prompt then slow answer
        for (int s = 0; s < 2; s++) begin
            val <= $random(seed);
            wr(`RTCEV_IDX_READREQ, 32'h8000);
            if (s) begin
                rd(`RTCEV_IDX_STATUS, 32'h80);
            end
            q = 32'h80;
            while (q[`RTCEV_STAT_BUSY]) begin
                apb(1'b0, {4'h0, `RTCEV_IDX_STATUS, 2'h0}, 32'h0);
            end
            rd(`RTCEV_IDX_COUNT, val);
            irq_is(1'b1);
            wr(s ? `RTCEV_IDX_INTERRUPT_ENABLE_CLEAR : `RTCEV_IDX_INTFLAGCLR, 32'h40);
            irq_is(1'b0);
        end
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
